// ==== pkg/gyro_seq_pkg.sv ====
// Function
// - status bit 7 flags integrity error, bit 6 flags start-up phase
// - status bit 5 flags operation outside operating conditions
// - status bit 4 flags overload; bits 0-2 name overloaded X, Y, Z
// - status bit 3 flags channel error; bits 0-2 name failing X, Y, Z
// - external reset input is active low, pulled inactive when unconnected; external_reset_low has no pull here
// - external reset restarts the controller into initialisation, no power cycle
// - initialisation entered on power-on, external reset, reset command, service exit
// - init settles references, syncs channels, sends part, serial, config datagrams
// - normal mode entered only after the three identification datagrams
// - in normal mode identification datagrams are resent on host request
// - after power-up measuring and transmitting start without host action
// - measurement datagrams keep flowing whatever the status byte reports
// - channels sampled at 1000 per second, output at chosen rate or trigger
package gyro_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SAMPLE_RATE_HZ = 1000;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int SETTLE_US = 1000;
  localparam int SETTLE_CYC = (CLK_HZ / 1000000) * SETTLE_US;

  // ----------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [15:0] RST_OUT_DIV = 16'h0001;
  localparam int CTRL_TRIG_BIT = 16;
  localparam logic [2:0] RST_IRQ_EN = 3'h0;

  // ----------------------------------------------------------------
  // status byte and interrupt bit positions
  // ----------------------------------------------------------------
  localparam int ST_INTEG = 7;
  localparam int ST_START = 6;
  localparam int ST_OUTSIDE = 5;
  localparam int ST_OVLD = 4;
  localparam int ST_CHERR = 3;
  localparam int IRQ_INIT = 0;
  localparam int IRQ_NORMAL = 1;
  localparam int IRQ_FAULT = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_SETTLE = 3'h0,
    M_SYNC = 3'h1,
    M_ID_PART = 3'h3,
    M_ID_SERIAL = 3'h2,
    M_ID_CONFIG = 3'h6,
    M_NORMAL = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    DG_PART = 2'h0,
    DG_SERIAL = 2'h1,
    DG_CONFIG = 2'h2,
    DG_MEAS = 2'h3
  } dg_kind_t;

  typedef struct packed {
    logic integrity;
    logic outside;
    logic [2:0] overload;
    logic [2:0] chan_err;
  } fault_t;

  typedef struct packed {
    logic valid;
    dg_kind_t kind;
  } id_req_t;

  typedef struct packed {
    logic start;
    dg_kind_t kind;
    logic [7:0] status;
  } dg_req_t;

endpackage

// ==== rtl/gyro_mode_seq.sv ====
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gyro_mode_seq
  import gyro_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = gyro_seq_pkg::SETTLE_CYC,
  parameter int SAMPLE_CYCLES = gyro_seq_pkg::SAMPLE_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host and link events
  input wire logic external_reset_low,
  input wire logic reset_cmd,
  input wire logic service_exit,
  input wire logic ext_trigger,
  input wire gyro_seq_pkg::id_req_t id_req,
  // diagnostics
  input wire gyro_seq_pkg::fault_t faults,
  // datagram transmitter
  output gyro_seq_pkg::dg_req_t dg_req,
  input wire logic tx_done,
  // channel control and status
  output logic chan_sync,
  output logic sample_tick,
  output gyro_seq_pkg::mode_t mode,
  output logic irq
);
  import gyro_seq_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ctl_rst;
  logic [31:0] settle_cnt;
  logic [31:0] sample_cnt;
  logic [15:0] out_cnt;
  logic [15:0] out_div;
  logic trig_mode;
  logic busy;
  logic meas_due;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;
  logic [2:0] irq_set;
  logic [7:0] status_byte;
  logic wr_en;
  logic wr_clr;
  logic ack_err;

  // controller reset: pin low, reset command or service exit
  assign ctl_rst = !external_reset_low || reset_cmd || service_exit;

  // ----------------------------------------------------------------
  // status byte composition
  // ----------------------------------------------------------------
  // channel bits merge both causes; bits 3 and 4 say which cause
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[ST_INTEG] = faults.integrity;
    status_byte[ST_START] = (mode != M_NORMAL);
    status_byte[ST_OUTSIDE] = faults.outside;
    status_byte[ST_OVLD] = |faults.overload;
    status_byte[ST_CHERR] = |faults.chan_err;
    status_byte[2:0] = faults.overload | faults.chan_err;
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  // power-on enters settle through presetn; no host action needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= M_SETTLE;
    else if (ctl_rst)
      mode <= M_SETTLE;
    else
    begin
      case (mode)
        M_SETTLE:
          if (settle_cnt >= 32'(SETTLE_CYCLES - 1))
            mode <= M_SYNC;
        M_SYNC: mode <= M_ID_PART;
        M_ID_PART:
          if (busy && tx_done)
            mode <= M_ID_SERIAL;
        M_ID_SERIAL:
          if (busy && tx_done)
            mode <= M_ID_CONFIG;
        M_ID_CONFIG:
          if (busy && tx_done)
            mode <= M_NORMAL;
        M_NORMAL: mode <= M_NORMAL;
        default: mode <= M_SETTLE;
      endcase
    end
  end

  // reference settle timer, runs only while settling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_cnt <= 32'h0;
    else if (ctl_rst || mode != M_SETTLE)
      settle_cnt <= 32'h0;
    else
      settle_cnt <= settle_cnt + 32'h1;
  end

  // one-cycle channel reset and resync pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chan_sync <= 1'b0;
    else
      chan_sync <= (mode == M_SETTLE) && !ctl_rst &&
        (settle_cnt >= 32'(SETTLE_CYCLES - 1));
  end

  // ----------------------------------------------------------------
  // internal sampling and output pacing
  // ----------------------------------------------------------------
  // 1000 per second tick; sampling starts only after the sync pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_cnt <= 32'h0;
      sample_tick <= 1'b0;
    end
    else if (ctl_rst || mode == M_SETTLE)
    begin
      sample_cnt <= 32'h0;
      sample_tick <= 1'b0;
    end
    else if (sample_cnt >= 32'(SAMPLE_CYCLES - 1))
    begin
      sample_cnt <= 32'h0;
      sample_tick <= 1'b1;
    end
    else
    begin
      sample_cnt <= sample_cnt + 32'h1;
      sample_tick <= 1'b0;
    end
  end

  // output due every out_div samples, or on trigger in trigger mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_cnt <= 16'h0000;
      meas_due <= 1'b0;
    end
    else if (ctl_rst || mode != M_NORMAL)
    begin
      out_cnt <= 16'h0000;
      meas_due <= 1'b0;
    end
    else
    begin
      if (trig_mode)
        out_cnt <= 16'h0000;
      else if (sample_tick && out_cnt >= out_div - 16'h1)
        out_cnt <= 16'h0000;
      else if (sample_tick)
        out_cnt <= out_cnt + 16'h1;
      // a due output waits while the transmitter is busy
      if (trig_mode ? ext_trigger :
          (sample_tick && out_cnt >= out_div - 16'h1))
        meas_due <= 1'b1;
      else if (dg_req.start && dg_req.kind == DG_MEAS)
        meas_due <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // datagram launch
  // ----------------------------------------------------------------
  // identification requests beat measurements; only one in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dg_req <= '0;
      busy <= 1'b0;
    end
    else if (ctl_rst)
    begin
      dg_req <= '0;
      busy <= 1'b0;
    end
    else
    begin
      dg_req.start <= 1'b0;
      if (busy && tx_done)
        busy <= 1'b0;
      else if (!busy && !dg_req.start)
      begin
        case (mode)
          M_ID_PART, M_ID_SERIAL, M_ID_CONFIG:
          begin
            dg_req.start <= 1'b1;
            dg_req.kind <= (mode == M_ID_PART) ? DG_PART :
              (mode == M_ID_SERIAL) ? DG_SERIAL : DG_CONFIG;
            dg_req.status <= status_byte;
            busy <= 1'b1;
          end
          M_NORMAL:
            if (id_req.valid && id_req.kind != DG_MEAS)
            begin
              dg_req.start <= 1'b1;
              dg_req.kind <= id_req.kind;
              dg_req.status <= status_byte;
              busy <= 1'b1;
            end
            else if (meas_due)
            begin
              dg_req.start <= 1'b1;
              dg_req.kind <= DG_MEAS;
              dg_req.status <= status_byte;
              busy <= 1'b1;
            end
          default: busy <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait, unmapped answers pslverr
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign wr_clr = wr_en && paddr == ADDR_IRQ_CLR;
  assign ack_err = !(paddr == ADDR_CTRL || paddr == ADDR_STATE ||
    paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_CLR ||
    paddr == ADDR_IRQ_EN);

  // answer is prepared in setup and shown through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && ack_err;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ADDR_CTRL: prdata <= {15'h0, trig_mode, out_div};
          ADDR_STATE: prdata <= {21'h0, mode, status_byte};
          ADDR_IRQ_STAT: prdata <= {29'h0, irq_stat};
          ADDR_IRQ_EN: prdata <= {29'h0, irq_en};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // control register; a zero divider is held at one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_div <= RST_OUT_DIV;
      trig_mode <= 1'b0;
    end
    else if (wr_en && paddr == ADDR_CTRL)
    begin
      out_div <= (pwdata[15:0] == 16'h0000) ? RST_OUT_DIV : pwdata[15:0];
      trig_mode <= pwdata[CTRL_TRIG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky status, set beats clear
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_set = 3'h0;
    irq_set[IRQ_INIT] = ctl_rst;
    irq_set[IRQ_NORMAL] = (mode == M_ID_CONFIG) && busy && tx_done &&
      !ctl_rst;
    irq_set[IRQ_FAULT] = dg_req.start && (|dg_req.status[7:3] &
      !dg_req.status[ST_START] | dg_req.status[ST_INTEG]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 3'h0;
      irq_en <= RST_IRQ_EN;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~(wr_clr ? pwdata[2:0] : 3'h0)) | irq_set;
      if (wr_en && paddr == ADDR_IRQ_EN)
        irq_en <= pwdata[2:0];
      irq <= |(irq_stat & irq_en);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_startup_flag;
    @(posedge pclk) disable iff (!presetn)
    dg_req.start |-> dg_req.status[ST_START] == ($past(mode) != M_NORMAL);
  endproperty
  a_startup_flag: assert property (p_startup_flag)
    else $error("start-up flag wrong in datagram");

  property p_integrity;
    @(posedge pclk) disable iff (!presetn)
    $rose(dg_req.start) |-> dg_req.status[ST_INTEG] ==
      $past(faults.integrity);
  endproperty
  a_integrity: assert property (p_integrity)
    else $error("integrity bit does not follow fault");

  property p_outside;
    @(posedge pclk) disable iff (!presetn)
    $rose(dg_req.start) |-> dg_req.status[ST_OUTSIDE] ==
      $past(faults.outside);
  endproperty
  a_outside: assert property (p_outside)
    else $error("outside-conditions bit does not follow fault");

  property p_overload;
    @(posedge pclk) disable iff (!presetn)
    $rose(dg_req.start) && $past(|faults.overload) |->
      dg_req.status[ST_OVLD] &&
      ((dg_req.status[2:0] & $past(faults.overload)) ==
      $past(faults.overload));
  endproperty
  a_overload: assert property (p_overload)
    else $error("overload channels not flagged");

  property p_chan_err;
    @(posedge pclk) disable iff (!presetn)
    $rose(dg_req.start) && $past(|faults.chan_err) |->
      dg_req.status[ST_CHERR] &&
      ((dg_req.status[2:0] & $past(faults.chan_err)) ==
      $past(faults.chan_err));
  endproperty
  a_chan_err: assert property (p_chan_err)
    else $error("error channels not flagged");

  property p_ext_reset;
    @(posedge pclk) disable iff (!presetn)
    !external_reset_low |=> mode == M_SETTLE && !busy;
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external reset did not restart init");

  property p_normal_entry;
    @(posedge pclk) disable iff (!presetn)
    mode == M_NORMAL && $past(mode) != M_NORMAL |->
      $past(mode) == M_ID_CONFIG && $past(tx_done);
  endproperty
  a_normal_entry: assert property (p_normal_entry)
    else $error("normal mode entered early");

  property p_sync_seq;
    @(posedge pclk) disable iff (!presetn)
    mode == M_SYNC && !ctl_rst |-> chan_sync ##1 mode == M_ID_PART
      ##1 (dg_req.start && dg_req.kind == DG_PART);
  endproperty
  a_sync_seq: assert property (p_sync_seq)
    else $error("sync and part datagram order broken");

  property p_id_resend;
    @(posedge pclk) disable iff (!presetn)
    mode == M_NORMAL && id_req.valid && id_req.kind != DG_MEAS &&
      !busy && !dg_req.start && !ctl_rst |=>
      dg_req.start && dg_req.kind == $past(id_req.kind);
  endproperty
  a_id_resend: assert property (p_id_resend)
    else $error("identification request not served");

  property p_tick_gap;
    @(posedge pclk) disable iff (!presetn)
    sample_tick |=> !sample_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample ticks too close");

endmodule // gyro_mode_seq

// ==== sim/gyro_host_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// serializer and host end of the datagram link
// ------------------------------------------------------------
module gyro_host_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // datagram link
  input wire gyro_seq_pkg::dg_req_t dg_req,
  output logic tx_done,
  // bench control and log
  input wire logic [7:0] delay,
  output logic [7:0] dg_count
);
  import gyro_seq_pkg::*;

  logic [1:0] kind_log [0:255];
  logic [7:0] stat_log [0:255];
  logic busy;
  logic [7:0] left;

  // one datagram in flight; bench picks a fast or a slow line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      tx_done <= 1'b0;
      dg_count <= 8'h00;
      left <= 8'h00;
    end
    else
    begin
      tx_done <= 1'b0;
      if (dg_req.start)
      begin
        busy <= 1'b1;
        left <= delay;
        kind_log[dg_count] <= dg_req.kind;
        stat_log[dg_count] <= dg_req.status;
        dg_count <= dg_count + 8'h01;
      end
      else if (busy && left == 8'h00)
      begin
        tx_done <= 1'b1;
        busy <= 1'b0;
      end
      else if (busy)
        left <= left - 8'h01;
    end
  end
endmodule // gyro_host_model

// ==== sim/gyro_init_mode_and_status_test.sv ====
`timescale 1ns/1ps
module gyro_init_mode_and_status_test;
  import gyro_seq_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, delay, dg_count, base;
  logic [31:0] pwdata, prdata, rd;
  logic external_reset_low, reset_cmd, service_exit, ext_trigger;
  logic tx_done, chan_sync, sample_tick, irq, err;
  id_req_t id_req;
  fault_t faults;
  dg_req_t dg_req;
  mode_t mode;
  int fail_count, checks, k;
  int sync_seen = 0;
  logic [7:0] ftab [0:3] = '{8'h80, 8'h58, 8'h05, 8'hCC};
  logic [7:0] stab [0:3] = '{8'h80, 8'h33, 8'h0D, 8'hBD};

  gyro_mode_seq #(.SETTLE_CYCLES(20), .SAMPLE_CYCLES(30)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .external_reset_low(external_reset_low), .reset_cmd(reset_cmd),
    .service_exit(service_exit), .ext_trigger(ext_trigger),
    .id_req(id_req), .faults(faults), .dg_req(dg_req), .tx_done(tx_done),
    .chan_sync(chan_sync), .sample_tick(sample_tick), .mode(mode),
    .irq(irq));

  gyro_host_model i_host (.pclk(pclk), .presetn(presetn), .dg_req(dg_req),
    .tx_done(tx_done), .delay(delay), .dg_count(dg_count));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #20 pclk = ~pclk;

  // channel resync pulses, one per init pass
  always @(posedge pclk)
    if (chan_sync === 1'b1)
      sync_seen++;

  task tally_and_finish;
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 32'h1, {31'h0, pready});
  endtask

  // bounded wait for n datagrams in the host log
  task wait_dg(input logic [7:0] n);
    k = 0;
    while (dg_count !== n && k < 3000)
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk("datagram count", n, dg_count);
  endtask

  // full init pass: three id datagrams, then measurements
  task init_seq(input logic [7:0] b);
    wait_dg(b + 8'd3);
    chk("mode in config", M_ID_CONFIG, mode);
    for (int i = 0; i < 3; i++)
    begin
      chk("id kind", i, i_host.kind_log[b + i]);
      chk("startup bit", 32'h1, i_host.stat_log[b + i][6]);
    end
    wait_dg(b + 8'd4);
    chk("mode normal", M_NORMAL, mode);
    chk("meas kind", DG_MEAS, i_host.kind_log[b + 3]);
    chk("meas status", 32'h0, i_host.stat_log[b + 3]);
  endtask

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; reset_cmd = 0; service_exit = 0;
    external_reset_low = 1;
    ext_trigger = 0; id_req = '0; faults = '0; delay = 8'd3;
    fail_count = 0; checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    init_seq(8'h00);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, err);
    // sample period measured between two ticks
    k = 0;
    @(posedge sample_tick);
    do
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    while (sample_tick !== 1'b1 && k < 100);
    chk("tick period", 30, k);
    // each reset source, slow line to stretch the id phase
    for (int c = 0; c < 3; c++)
    begin
      @(posedge pclk);
      delay <= 8'd12;
      external_reset_low <= (c != 0);
      reset_cmd <= (c == 1);
      service_exit <= (c == 2);
      @(posedge pclk);
      {reset_cmd, service_exit} <= 2'b00;
      external_reset_low <= 1'b1;
      #1;
      chk("init entry", M_SETTLE, mode);
      base = dg_count;
      init_seq(base);
    end
    delay <= 8'd3;
    apb(1'b1, ADDR_IRQ_EN, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq on", 32'h1, irq);
    apb(1'b1, ADDR_IRQ_CLR, 32'h7);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq stat clr", 32'h0, rd);
    chk("irq off", 32'h0, irq);
    // fault table; the fault interrupt stays masked meanwhile
    for (int f = 0; f < 4; f++)
    begin
      @(posedge pclk);
      faults <= ftab[f];
      base = dg_count;
      wait_dg(base + 8'd2);
      chk("meas kind", DG_MEAS, i_host.kind_log[base + 1]);
      chk("status", stab[f], i_host.stat_log[base + 1]);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk("state reg", {M_NORMAL, stab[f]}, rd[10:0]);
    end
    chk("irq masked", 32'h0, irq);
    apb(1'b1, ADDR_IRQ_EN, 32'h7);
    faults <= '0;
    repeat (3) @(posedge pclk);
    chk("irq fault", 32'h1, irq);
    // id resends on request, start-up flag clear
    for (int r = 0; r < 3; r++)
    begin
      @(posedge pclk);
      id_req <= {1'b1, dg_kind_t'(r)};
      k = 0;
      do
      begin
        @(posedge pclk);
        k++;
      end
      while (!(dg_req.start === 1'b1 && dg_req.kind === r) && k < 200);
      id_req <= '0;
      chk("resend", r, dg_req.kind);
      chk("resend b6", 32'h0, dg_req.status[6]);
    end
    // trigger mode stops the free output
    apb(1'b1, ADDR_CTRL, 32'h0001_0001);
    repeat (40) @(posedge pclk);
    base = dg_count;
    repeat (70) @(posedge pclk);
    chk("no free output", base, dg_count);
    ext_trigger <= 1'b1;
    @(posedge pclk);
    ext_trigger <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("trigger output", base + 8'd1, dg_count);
    chk("sync pulses", 32'h4, sync_seen);
    tally_and_finish;
  end
endmodule // gyro_init_mode_and_status_test
